/* File: hdl/rpio_pkg.sv */
// Function
// - Twenty-four control inputs, each mapped to one function from a fixed list.
// - Input activity is ignored unless the local/remote state says remote.
// - Local/remote state changes only from the local operator interface.
// - An unmapped input has no effect at any level.
// - Carrier input issues the same on/off command as the local buttons.
// - Reset input triggers a full system reset like the local button.
// - Active power-step input steps power 100 W, repeating every half second.
// - Exciter input selects exciter A or B per its control mode.
// - Switchover input toggles switchover enable on each falling-edge activation by default.
// - Interface reboot input asserts a hardware watchdog reset of the operator interface.
// - Profile input makes its stored profile active when it activates.
// - Factory defaults: two carrier, two power-step, two exciter inputs, one switchover.
// - Falling-activate uses low or falling edge, rising-activate high or rising edge; the code acts on the edge only, never on a held level.
// - Falling-deactivate uses low or falling edge, rising-deactivate high or rising edge; the code acts on the edge only, never on a held level.
// - Toggle mode alternates the function on each edge of chosen polarity.
// - Two-edge modes activate on one polarity, deactivate on the other, both selectable.
// - Power-step inputs are level sensitive with polarity per increase and decrease.
// - Profile inputs are level sensitive with selectable active level.
// - Each input's sampled level is readable with its function and mode.
// - Twenty-four status outputs, each mapped to one condition from a list.
// - Each output drives low when condition true, or low when false, by choice.
// - Conditions: carrier, remote, exciter, switchover, profile active, program loss.
package rpio_pkg;

	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------
	localparam int NUM_CH = 24;
	localparam int CLK_HZ = 40000000;
	localparam int STEP_PERIOD_MS = 500;
	localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_PERIOD_MS;
	localparam logic [15:0] POWER_STEP_W = 16'h0064;
	localparam logic [15:0] POWER_MAX_W_DFLT = 16'h4E20;
	localparam logic [1:0] ARM_CYCLES = 2'h3;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [8:0] IN_CFG_BASE = 9'h000;
	localparam logic [8:0] IN_CFG_LAST = 9'h05C;
	localparam logic [8:0] OUT_CFG_BASE = 9'h080;
	localparam logic [8:0] OUT_CFG_LAST = 9'h0DC;
	localparam logic [8:0] CTRL_ADDR = 9'h100;
	localparam logic [8:0] LEVEL_ADDR = 9'h104;
	localparam logic [8:0] STATE_ADDR = 9'h108;
	localparam logic [8:0] POWER_ADDR = 9'h10C;
	localparam logic [8:0] CMD_ADDR = 9'h110;

	// Field positions.
	localparam int CTRL_REMOTE_BIT = 0;
	localparam int CMD_CARRIER_ON_BIT = 0;
	localparam int CMD_CARRIER_OFF_BIT = 1;
	localparam int CMD_RESET_BIT = 2;

	// ----------------------------------------------------------------
	// Functions, modes, conditions
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		FN_NONE = 4'h0, FN_CARRIER = 4'h1, FN_RESET = 4'h2, FN_POWER_INC = 4'h3,
		FN_POWER_DEC = 4'h4, FN_EXCITER = 4'h5, FN_AUTOSW = 4'h6, FN_WDOG = 4'h7,
		FN_PROFILE = 4'h8
	} rpio_func_t;

	typedef enum logic [3:0] {
		MD_FALL_ON = 4'h0, MD_RISE_ON = 4'h1, MD_FALL_OFF = 4'h2, MD_RISE_OFF = 4'h3,
		MD_FALL_TOG = 4'h4, MD_RISE_TOG = 4'h5, MD_RISE_ON_FALL_OFF = 4'h6,
		MD_FALL_ON_RISE_OFF = 4'h7, MD_ACT_HIGH = 4'h8, MD_ACT_LOW = 4'h9
	} rpio_mode_t;

	typedef enum logic [2:0] {
		CD_NONE = 3'h0, CD_CARRIER = 3'h1, CD_REMOTE = 3'h2, CD_EXCITER_A = 3'h3,
		CD_AUTOSW = 3'h4, CD_PROFILE = 3'h5, CD_PROG_LOSS = 3'h6
	} rpio_cond_t;

	typedef struct packed {
		logic [2:0] prof;
		rpio_mode_t mode;
		rpio_func_t func;
	} rpio_in_cfg_t;

	typedef struct packed {
		logic [2:0] prof;
		logic low_when_false;
		rpio_cond_t cond;
	} rpio_out_cfg_t;

	// Reset values of the control and state registers.
	localparam rpio_in_cfg_t IN_CFG_RST = '{3'h0, MD_FALL_ON, FN_NONE};
	localparam rpio_out_cfg_t OUT_CFG_RST = '{3'h0, 1'b0, CD_NONE};
	localparam logic [15:0] POWER_RST = 16'h0000;

	// Factory input assignments on the first seven channels.
	function automatic rpio_in_cfg_t rpio_in_dflt(input int ch);
		rpio_in_cfg_t c;
		c = IN_CFG_RST;
		case (ch)
			0: c = '{3'h0, MD_FALL_ON, FN_CARRIER};
			1: c = '{3'h0, MD_FALL_OFF, FN_CARRIER};
			2: c = '{3'h0, MD_ACT_LOW, FN_POWER_INC};
			3: c = '{3'h0, MD_ACT_LOW, FN_POWER_DEC};
			4: c = '{3'h0, MD_FALL_OFF, FN_EXCITER};
			5: c = '{3'h0, MD_FALL_ON, FN_EXCITER};
			6: c = '{3'h0, MD_FALL_TOG, FN_AUTOSW};
			default: c = IN_CFG_RST;
		endcase
		return c;
	endfunction

endpackage

/* File: hdl/rpio_top.sv */
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module rpio_top
	import rpio_pkg::*;
#(
	parameter int STEP_CYC = STEP_CYCLES,
	parameter logic [15:0] POWER_MAX_W = POWER_MAX_W_DFLT
)
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port.
	input wire logic [8:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Remote parallel lines.
	input wire logic [23:0] remote_in,
	output logic [23:0] remote_out,
	// Transmitter status input.
	input wire logic prog_loss,
	// Transmitter controls.
	output logic carrier_req,
	output logic sys_reset,
	output logic wdog_reset,
	output logic exciter_b,
	output logic autosw_en,
	output logic [15:0] power_level,
	output logic profile_valid,
	output logic [2:0] profile_sel
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	rpio_in_cfg_t in_cfg_reg [0:NUM_CH-1];
	rpio_out_cfg_t out_cfg_reg [0:NUM_CH-1];
	logic remote_reg;
	logic [31:0] rdata_reg;
	logic [1:0] arm_reg;

	// Decoding of the register port.
	wire logic in_hit = (reg_addr >= IN_CFG_BASE) && (reg_addr <= IN_CFG_LAST);
	wire logic out_hit = (reg_addr >= OUT_CFG_BASE) && (reg_addr <= OUT_CFG_LAST);
	wire logic [4:0] reg_idx = reg_addr[6:2];
	wire logic word_ok = (reg_addr[1:0] == 2'h0);
	wire logic ctrl_wr = reg_wr && word_ok && (reg_addr == CTRL_ADDR);
	wire logic power_wr = reg_wr && word_ok && (reg_addr == POWER_ADDR);
	wire logic cmd_wr = reg_wr && word_ok && (reg_addr == CMD_ADDR);
	wire logic in_wr = reg_wr && word_ok && in_hit;
	wire logic out_wr = reg_wr && word_ok && out_hit;
	wire logic cmd_on = cmd_wr && reg_wdata[CMD_CARRIER_ON_BIT];
	wire logic cmd_off = cmd_wr && reg_wdata[CMD_CARRIER_OFF_BIT];
	wire logic cmd_reset = cmd_wr && reg_wdata[CMD_RESET_BIT];
	wire logic armed = (arm_reg == ARM_CYCLES);

	// ----------------------------------------------------------------
	// Per-channel sampling and event decode
	// ----------------------------------------------------------------
	logic [NUM_CH-1:0] ch_level;
	logic [NUM_CH-1:0] ch_act;
	logic [NUM_CH-1:0] ch_deact;
	logic [NUM_CH-1:0] ch_tog;
	logic [NUM_CH-1:0] ch_hold;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			logic meta_reg;
			logic sync_reg;
			logic prev_reg;
			logic fresh_reg;
			wire logic cfg_wr = in_wr && (reg_idx == 5'(g));
			wire logic rise = sync_reg && !prev_reg;
			wire logic fall = !sync_reg && prev_reg;
			wire rpio_mode_t md = in_cfg_reg[g].mode;
			// Events are dropped while local, before arming, or right after a
			// reconfiguration, so a stale edge never acts under new settings.
			wire logic live = remote_reg && armed && !fresh_reg && !cfg_wr
				&& (in_cfg_reg[g].func != FN_NONE);
			wire logic a_e = ((md == MD_FALL_ON) && fall) || ((md == MD_RISE_ON) && rise)
				|| ((md == MD_RISE_ON_FALL_OFF) && rise)
				|| ((md == MD_FALL_ON_RISE_OFF) && fall);
			wire logic d_e = ((md == MD_FALL_OFF) && fall) || ((md == MD_RISE_OFF) && rise)
				|| ((md == MD_RISE_ON_FALL_OFF) && fall)
				|| ((md == MD_FALL_ON_RISE_OFF) && rise);
			wire logic t_e = ((md == MD_FALL_TOG) && fall)
				|| ((md == MD_RISE_TOG) && rise);
			wire logic h_l = ((md == MD_ACT_HIGH) && sync_reg)
				|| ((md == MD_ACT_LOW) && !sync_reg);

			// Two-stage synchroniser; only the second stage feeds the edge logic.
			always_ff @(posedge clk_sys or negedge rst_b)
			begin
				if (!rst_b)
				begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
					prev_reg <= 1'b0;
					fresh_reg <= 1'b0;
				end
				else
				begin
					meta_reg <= remote_in[g];
					sync_reg <= meta_reg;
					prev_reg <= sync_reg;
					fresh_reg <= cfg_wr;
				end
			end

			assign ch_level[g] = sync_reg;
			assign ch_act[g] = live && a_e;
			assign ch_deact[g] = live && d_e;
			assign ch_tog[g] = live && t_e;
			assign ch_hold[g] = live && h_l;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Gathering of channel events per function
	// ----------------------------------------------------------------
	logic car_on;
	logic car_off;
	logic car_tog;
	logic rst_ev;
	logic inc_hold;
	logic dec_hold;
	logic exc_b;
	logic exc_a;
	logic exc_tog;
	logic asw_on;
	logic asw_off;
	logic asw_tog;
	logic wd_ev;
	logic prof_ev;
	logic [2:0] prof_idx;

	// Lowest channel wins when several profile inputs are active together.
	always_comb
	begin
		car_on = 1'b0;
		car_off = 1'b0;
		car_tog = 1'b0;
		rst_ev = 1'b0;
		inc_hold = 1'b0;
		dec_hold = 1'b0;
		exc_b = 1'b0;
		exc_a = 1'b0;
		exc_tog = 1'b0;
		asw_on = 1'b0;
		asw_off = 1'b0;
		asw_tog = 1'b0;
		wd_ev = 1'b0;
		prof_ev = 1'b0;
		prof_idx = 3'h0;
		for (int i = NUM_CH - 1; i >= 0; i--)
		begin
			case (in_cfg_reg[i].func)
				FN_CARRIER:
				begin
					car_on = car_on | ch_act[i];
					car_off = car_off | ch_deact[i];
					car_tog = car_tog | ch_tog[i];
				end
				FN_RESET: rst_ev = rst_ev | ch_act[i] | ch_tog[i] | ch_hold[i];
				FN_POWER_INC: inc_hold = inc_hold | ch_hold[i];
				FN_POWER_DEC: dec_hold = dec_hold | ch_hold[i];
				FN_EXCITER:
				begin
					exc_b = exc_b | ch_act[i];
					exc_a = exc_a | ch_deact[i];
					exc_tog = exc_tog | ch_tog[i];
				end
				FN_AUTOSW:
				begin
					asw_on = asw_on | ch_act[i];
					asw_off = asw_off | ch_deact[i];
					asw_tog = asw_tog | ch_tog[i];
				end
				FN_WDOG: wd_ev = wd_ev | ch_act[i] | ch_tog[i] | ch_hold[i];
				FN_PROFILE:
				begin
					if (ch_act[i] || ch_tog[i] || ch_hold[i])
					begin
						prof_ev = 1'b1;
						prof_idx = in_cfg_reg[i].prof;
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Transmitter state
	// ----------------------------------------------------------------
	logic carrier_reg;
	logic sys_reset_reg;
	logic wdog_reg;
	logic exciter_b_reg;
	logic autosw_reg;
	logic [15:0] power_reg;
	logic prof_valid_reg;
	logic [2:0] prof_reg;
	logic [24:0] step_cnt_reg;

	// Off wins over on, matching a panel where both buttons are pressed.
	wire logic carrier_next = (car_off || cmd_off) ? 1'b0
		: (car_on || cmd_on) ? 1'b1
		: car_tog ? !carrier_reg : carrier_reg;
	wire logic exciter_next = exc_a ? 1'b0 : exc_b ? 1'b1
		: exc_tog ? !exciter_b_reg : exciter_b_reg;
	wire logic autosw_next = asw_off ? 1'b0 : asw_on ? 1'b1
		: asw_tog ? !autosw_reg : autosw_reg;

	// Power stepping: first step at once, then one step per period held.
	// Opposing inputs held together cancel rather than fight.
	wire logic step_req = inc_hold ^ dec_hold;
	wire logic step_now = step_req && (step_cnt_reg == 25'h0);
	wire logic [15:0] power_up = (power_reg > POWER_MAX_W - POWER_STEP_W) ? POWER_MAX_W
		: power_reg + POWER_STEP_W;
	wire logic [15:0] power_dn = (power_reg < POWER_STEP_W) ? 16'h0000
		: power_reg - POWER_STEP_W;
	wire logic [15:0] power_next = power_wr ? reg_wdata[15:0]
		: !step_now ? power_reg
		: inc_hold ? power_up : power_dn;
	wire logic [24:0] step_cnt_next = !step_req ? 25'h0
		: step_now ? 25'(STEP_CYC - 1) : step_cnt_reg - 25'h1;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			carrier_reg <= 1'b0;
			sys_reset_reg <= 1'b0;
			wdog_reg <= 1'b0;
			exciter_b_reg <= 1'b0;
			autosw_reg <= 1'b0;
			power_reg <= POWER_RST;
			prof_valid_reg <= 1'b0;
			prof_reg <= 3'h0;
			step_cnt_reg <= 25'h0;
			arm_reg <= 2'h0;
		end
		else
		begin
			carrier_reg <= carrier_next;
			sys_reset_reg <= rst_ev || cmd_reset;
			wdog_reg <= wd_ev;
			exciter_b_reg <= exciter_next;
			autosw_reg <= autosw_next;
			power_reg <= power_next;
			step_cnt_reg <= step_cnt_next;
			if (prof_ev)
			begin
				prof_valid_reg <= 1'b1;
				prof_reg <= prof_idx;
			end
			if (!armed)
				arm_reg <= arm_reg + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// The whole word is stored in one edge, so a channel never runs on a
	// mix of old function and new mode.
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				in_cfg_reg[i] <= rpio_in_dflt(i);
				out_cfg_reg[i] <= OUT_CFG_RST;
			end
			remote_reg <= 1'b0;
		end
		else
		begin
			if (in_wr)
				in_cfg_reg[reg_idx] <= rpio_in_cfg_t'(reg_wdata[10:0]);
			if (out_wr)
				out_cfg_reg[reg_idx] <= rpio_out_cfg_t'(reg_wdata[6:0]);
			// Only the local operator port reaches this bit; no input function can.
			if (ctrl_wr)
				remote_reg <= reg_wdata[CTRL_REMOTE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	logic [NUM_CH-1:0] cond_true;
	logic [NUM_CH-1:0] out_next;
	logic [23:0] dout_reg;

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			case (out_cfg_reg[i].cond)
				CD_CARRIER: cond_true[i] = carrier_reg;
				CD_REMOTE: cond_true[i] = remote_reg;
				CD_EXCITER_A: cond_true[i] = !exciter_b_reg;
				CD_AUTOSW: cond_true[i] = autosw_reg;
				CD_PROFILE: cond_true[i] = prof_valid_reg && (prof_reg == out_cfg_reg[i].prof);
				CD_PROG_LOSS: cond_true[i] = prog_loss;
				default: cond_true[i] = 1'b0;
			endcase
			// Low when true unless the channel asks for low when false.
			out_next[i] = out_cfg_reg[i].low_when_false ? cond_true[i]
				: !cond_true[i];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			dout_reg <= 24'hFFFFFF;
		else
			dout_reg <= out_next;
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire logic [31:0] state_word = {8'h00, power_reg, prof_reg, prof_valid_reg,
		autosw_reg, exciter_b_reg, remote_reg, carrier_reg};
	wire logic [31:0] rd_mux = !word_ok ? 32'h0
		: in_hit ? {21'h0, in_cfg_reg[reg_idx]}
		: out_hit ? {25'h0, out_cfg_reg[reg_idx]}
		: (reg_addr == CTRL_ADDR) ? {31'h0, remote_reg}
		: (reg_addr == LEVEL_ADDR) ? {8'h00, ch_level}
		: (reg_addr == STATE_ADDR) ? state_word
		: (reg_addr == POWER_ADDR) ? {16'h0000, power_reg}
		: 32'h0;

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			rdata_reg <= 32'h0;
		else
			rdata_reg <= reg_rd ? rd_mux : 32'h0;
	end

	assign reg_rdata = rdata_reg;
	assign remote_out = dout_reg;
	assign carrier_req = carrier_reg;
	assign sys_reset = sys_reset_reg;
	assign wdog_reset = wdog_reg;
	assign exciter_b = exciter_b_reg;
	assign autosw_en = autosw_reg;
	assign power_level = power_reg;
	assign profile_valid = prof_valid_reg;
	assign profile_sel = prof_reg;

endmodule
`default_nettype wire

/* File: verification/rpio_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module rpio_sva
	import rpio_pkg::*;
#(
	parameter logic [15:0] POWER_MAX_W = POWER_MAX_W_DFLT
)
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port.
	input wire logic [8:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Remote lines and controls.
	input wire logic [23:0] remote_in,
	input wire logic [23:0] remote_out,
	input wire logic carrier_req,
	input wire logic [15:0] power_level,
	input wire logic profile_valid
);
	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	// One clock domain, so clocking and reset are declared once.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence rd_at(logic [8:0] a);
		reg_rd && reg_addr == a;
	endsequence
	sequence lines_quiet;
		$stable(remote_in) [*4];
	endsequence
	sequence cmd_wr(logic [1:0] v);
		reg_wr && reg_addr == CMD_ADDR && reg_wdata[1:0] == v;
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Outputs start high because every output begins unmapped, low when true.
	reset_out_a: assert property ($rose(rst_b) |-> remote_out == 24'hFFFFFF)
		else $error("status outputs not high after reset");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read answer");
	unmapped_read_a: assert property (reg_rd && reg_addr > CMD_ADDR
		|=> reg_rdata == 32'h0)
		else $error("unmapped read returned data");
	cmd_read_a: assert property (rd_at(CMD_ADDR) |=> reg_rdata == 32'h0)
		else $error("command register read not zero");
	level_read_a: assert property (lines_quiet ##0 rd_at(LEVEL_ADDR)
		|=> reg_rdata == {8'h00, $past(remote_in)})
		else $error("level read differs from quiet lines");
	carrier_on_a: assert property (cmd_wr(2'b01) |-> ##[1:2] carrier_req)
		else $error("carrier on command not followed");
	carrier_off_a: assert property (reg_wr && reg_addr == CMD_ADDR && reg_wdata[1]
		|-> ##[1:2] !carrier_req)
		else $error("carrier off command not followed");
	power_write_a: assert property (reg_wr && reg_addr == POWER_ADDR
		&& reg_wdata[15:0] <= POWER_MAX_W |=> power_level == $past(reg_wdata[15:0]))
		else $error("power write not taken");
	// Away from the clamp limits every unwritten change is one whole step.
	power_step_a: assert property ($changed(power_level) && !$past(reg_wr)
		&& $past(power_level) >= 16'h0064 && $past(power_level) <= POWER_MAX_W - 16'h0064
		|-> power_level == $past(power_level) + 16'h0064
		|| power_level == $past(power_level) - 16'h0064)
		else $error("power changed by other than one step");
	profile_hold_a: assert property (profile_valid |=> profile_valid)
		else $error("profile selection lost");
endmodule
bind rpio_top rpio_sva #(.POWER_MAX_W(POWER_MAX_W)) u_sva (.clk_sys(clk_sys), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .remote_in(remote_in), .remote_out(remote_out),
	.carrier_req(carrier_req), .power_level(power_level), .profile_valid(profile_valid));
`default_nettype wire

/* File: verification/rpio_rcu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rpio_rcu_model
(
	// Clock.
	input wire logic clk_sys,
	// Parallel lines towards the block.
	output var logic [23:0] remote_in
);
	// Idle lines sit high so falling-edge defaults stay quiet.
	initial remote_in = 24'hFFFFFF;

	// Moves one line after a clock edge and holds it, slow or prompt by hold.
	// A hold of two or more cycles lets each edge count exactly once.
	task automatic put(input int idx, input logic val, input int hold);
		@(posedge clk_sys);
		remote_in[idx] <= val;
		repeat (hold) @(posedge clk_sys);
		#1;
	endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import rpio_pkg::*;
	logic clk_sys;
	logic rst_b;
	logic [8:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr, reg_rd, prog_loss;
	logic [31:0] reg_rdata;
	logic [23:0] remote_in, remote_out;
	logic carrier_req, sys_reset, wdog_reset, exciter_b, autosw_en, profile_valid;
	logic [15:0] power_level;
	logic [2:0] profile_sel;
	logic e_c, e_xb, e_aw, e_pl, e_pa;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_rst = 0;
	int n_wd = 0;
	logic [31:0] icfg [8] = '{32'h001, 32'h021, 32'h093, 32'h094, 32'h025, 32'h005, 32'h046, 32'h0};
	logic [31:0] ocfg [7] = '{32'h01, 32'h09, 32'h02, 32'h06, 32'h55, 32'h03, 32'h0C};

	// STEP_CYC is shortened so a held power line steps within a short run.
	rpio_top #(.STEP_CYC(20)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.remote_in(remote_in), .remote_out(remote_out), .prog_loss(prog_loss),
		.carrier_req(carrier_req), .sys_reset(sys_reset), .wdog_reset(wdog_reset),
		.exciter_b(exciter_b), .autosw_en(autosw_en), .power_level(power_level),
		.profile_valid(profile_valid), .profile_sel(profile_sel));
	rpio_rcu_model rcu (.clk_sys(clk_sys), .remote_in(remote_in));

	// ----------------------------------------------------------------
	// Clock, pulse counters, watchdog
	// ----------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Pulses are counted so a doubled event shows up as a wrong total.
	always @(posedge clk_sys)
	begin
		if (sys_reset === 1'b1) n_rst <= n_rst + 1;
		if (wdog_reset === 1'b1) n_wd <= n_wd + 1;
	end
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_mismatch++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [8:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		check(what, reg_rdata, exp);
	endtask
	// Lets an event pass the synchroniser and the output stage, then compares.
	task automatic chk_state();
		repeat (4) @(posedge clk_sys);
		#1;
		check("carrier", {31'h0, carrier_req}, {31'h0, e_c});
		check("exciter", {31'h0, exciter_b}, {31'h0, e_xb});
		check("autosw", {31'h0, autosw_en}, {31'h0, e_aw});
		check("outputs", {8'h0, remote_out},
			{8'h0, 17'h1FFFF, e_aw, e_xb, ~e_pa, ~e_pl, 1'b0, e_c, ~e_c});
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rst_b = 1'b0;
		reg_addr = 9'h000;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		prog_loss = 1'b0;
		{e_c, e_xb, e_aw, e_pl, e_pa} = 5'h00;
		repeat (9) @(posedge clk_sys);
		#1;
		check("reset outputs", {8'h0, remote_out}, 32'h00FFFFFF);
		@(posedge clk_sys);
		rst_b <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd_chk("input default", 9'(4 * i), icfg[i]);
		rcu.put(0, 1'b0, 8);
		check("local carrier", {31'h0, carrier_req}, 32'h0);
		rcu.put(0, 1'b1, 8);
		wr(CTRL_ADDR, 32'h1);
		for (int i = 0; i < 7; i++)
			wr(9'(OUT_CFG_BASE + 4 * i), ocfg[i]);
		chk_state();
		rcu.put(0, 1'b0, 8);
		e_c = 1'b1;
		chk_state();
		rcu.put(0, 1'b1, 8);
		rcu.put(1, 1'b0, 8);
		e_c = 1'b0;
		chk_state();
		rcu.put(1, 1'b1, 8);
		rcu.put(5, 1'b0, 8);
		e_xb = 1'b1;
		chk_state();
		rcu.put(5, 1'b1, 8);
		rcu.put(4, 1'b0, 8);
		e_xb = 1'b0;
		chk_state();
		rcu.put(4, 1'b1, 8);
		rcu.put(6, 1'b0, 8);
		e_aw = 1'b1;
		chk_state();
		rcu.put(6, 1'b1, 8);
		rcu.put(6, 1'b0, 8);
		e_aw = 1'b0;
		rcu.put(6, 1'b1, 8);
		chk_state();
		rcu.put(7, 1'b0, 8);
		chk_state();
		rcu.put(7, 1'b1, 8);
		@(posedge clk_sys);
		prog_loss <= 1'b1;
		e_pl = 1'b1;
		chk_state();
		@(posedge clk_sys);
		prog_loss <= 1'b0;
		e_pl = 1'b0;
		// Rising-only modes: falls must be ignored, rises must act.
		wr(9'h02C, 32'h056);
		rcu.put(11, 1'b0, 8);
		rcu.put(11, 1'b1, 8);
		e_aw = 1'b1;
		chk_state();
		wr(9'h030, 32'h015);
		rcu.put(12, 1'b0, 8);
		rcu.put(12, 1'b1, 8);
		e_xb = 1'b1;
		chk_state();
		// Channel 0 now turns on at rising and off at falling edges.
		wr(9'h000, 32'h061);
		rcu.put(0, 1'b0, 8);
		rcu.put(0, 1'b1, 8);
		e_c = 1'b1;
		chk_state();
		rcu.put(0, 1'b0, 8);
		e_c = 1'b0;
		chk_state();
		// Back to falling-on first, so the rise below leaves the carrier off.
		wr(9'h000, 32'h001);
		rcu.put(0, 1'b1, 8);
		wr(CMD_ADDR, 32'h1);
		e_c = 1'b1;
		chk_state();
		wr(CMD_ADDR, 32'h3);
		e_c = 1'b0;
		chk_state();
		wr(CMD_ADDR, 32'h4);
		wr(9'h020, 32'h002);
		wr(9'h024, 32'h007);
		rcu.put(8, 1'b0, 8);
		rcu.put(9, 1'b0, 8);
		check("reset pulses", n_rst, 32'd2);
		check("watchdog pulses", n_wd, 32'd1);
		rcu.put(8, 1'b1, 8);
		rcu.put(9, 1'b1, 8);
		wr(9'h028, 32'h598);
		rcu.put(10, 1'b0, 8);
		e_pa = 1'b1;
		chk_state();
		check("profile", {28'h0, profile_valid, profile_sel}, 32'hD);
		rd_chk("levels", LEVEL_ADDR, 32'h00FFFBFF);
		rcu.put(10, 1'b1, 8);
		wr(POWER_ADDR, 32'h3E8);
		rcu.put(2, 1'b0, 50);
		rcu.put(2, 1'b1, 8);
		check("power up", {16'h0, power_level}, 32'h514);
		rcu.put(3, 1'b0, 10);
		rcu.put(3, 1'b1, 8);
		check("power down", {16'h0, power_level}, 32'h4B0);
		rd_chk("power", POWER_ADDR, 32'h4B0);
		rd_chk("state", STATE_ADDR, 32'h0004B0BE);
		rd_chk("output cfg", 9'h090, 32'h55);
		rd_chk("unmapped", 9'h1FC, 32'h0);
		rd_chk("command", CMD_ADDR, 32'h0);
		rd_chk("misaligned", 9'h102, 32'h0);
		rd_chk("remote kept", CTRL_ADDR, 32'h1);
		wrap_up();
	end
endmodule
`default_nettype wire
